// ### hdl/ecs_top.sv
// Conversion sequencer: busy/eoc/first-word timing, result registers, readout and standby.
// Assumes all control pins are asynchronous to clk and the converter core presents
// its finished result on adc_result, in the clk domain, when the 15th bit edge arrives.
// Requirements on this block and its host
// RQ1 - Both select inputs high choose the external conversion clock.
// RQ2 - Host keeps the external conversion clock at or below 5 MHz.
// RQ3 - Host waits 200 ns after start before the first clock fall.
// RQ4 - Start rising edge raises busy.
// RQ5 - No output changes before the 14th fall of the first conversion.
// RQ6 - 14th fall of first conversion: pointer to register 1, first flag high.
// RQ7 - 15th fall: eoc low and result stored in its register.
// RQ8 - 16th fall of every conversion returns eoc high.
// RQ9 - Each further selected channel takes another 16 clock pulses.
// RQ10 - Last conversion: busy and eoc low on 15th fall, eoc high on 16th.
// RQ11 - Read while eoc low places register 1 on the data bus.
// RQ12 - Standby input low enters low-current standby.
// RQ13 - Standby input high leaves standby.
// RQ14 - Data drivers keep working during standby.
// RQ15 - Host may enter standby after busy falls, leave before next start.
// RQ16 - Host allows wake-up time before starting a conversion.
// RQ17 - Data lines driven only while chip select and read are low.
// RQ18 - After the sequence, each read rising edge advances the pointer.
// RQ19 - During a sequence the pointer waits until the next result is stored.
// RQ20 - Reading the last result returns the pointer to register 1.
// RQ21 - Start edges while busy are ignored.
// RQ22 - Standby requested during a sequence takes effect after busy falls.
`timescale 1ns/1ns
`default_nettype none

module ecs_top (
	input  wire logic                          clk,
	input  wire logic                          rst,
	input  wire logic                          hw_sw_select,
	input  wire logic                          clock_source_select,
	input  wire logic                          conv_start_n,
	input  wire logic                          ext_conv_clock,
	input  wire logic                          cs_n,
	input  wire logic                          rd_n,
	input  wire logic                          standby_n,
	input  wire logic [ecs_pkg::NUM_REGS-1:0]  channel_sel,
	input  wire logic [ecs_pkg::DATA_W-1:0]    adc_result,
	output var  ecs_pkg::ecs_status_t          status,
	output logic      [ecs_pkg::DATA_W-1:0]    data_out,
	output logic                               data_oe,
	output logic                               standby_active,
	output logic                               ext_clock_mode
);
	import ecs_pkg::*;

	// ==========================================================
	// Pin synchronisers
	logic [PIN_CNT-1:0] pin_raw;
	logic [PIN_CNT-1:0] s1_q;
	logic [PIN_CNT-1:0] s2_q;
	logic [PIN_CNT-1:0] s3_q;
	logic [PIN_CNT-1:0] pin_q;
	logic [PIN_CNT-1:0] pin_prev_q;
	logic [PIN_CNT-1:0] pin_rise;
	logic [PIN_CNT-1:0] pin_fall;

	assign pin_raw = {standby_n, rd_n, cs_n, ext_conv_clock, conv_start_n,
			clock_source_select, hw_sw_select};

	genvar g;
	generate
		for (g = 0; g < PIN_CNT; g++)
		begin : g_sync
			// A level is accepted only once the second and third stages agree.
			always_ff @(posedge clk or posedge rst)
			begin
				if (rst)
				begin
					s1_q[g]       <= PIN_RST[g];
					s2_q[g]       <= PIN_RST[g];
					s3_q[g]       <= PIN_RST[g];
					pin_q[g]      <= PIN_RST[g];
					pin_prev_q[g] <= PIN_RST[g];
				end
				else
				begin
					s1_q[g]       <= pin_raw[g];
					s2_q[g]       <= s1_q[g];
					s3_q[g]       <= s2_q[g];
					pin_prev_q[g] <= pin_q[g];
					if (s2_q[g] == s3_q[g])
					begin
						pin_q[g] <= s3_q[g];
					end
				end
			end
		end
	endgenerate

	assign pin_rise = pin_q & ~pin_prev_q;
	assign pin_fall = ~pin_q & pin_prev_q;

	// ==========================================================
	// Conversion clock selection
	logic [DIV_W-1:0] div_q;
	logic             int_tick;
	logic             tick;

	assign int_tick = (div_q == DIV_W'(INT_DIV - 1));
	// RQ1 external clock select
	assign ext_clock_mode = pin_q[PIN_HWSW] & pin_q[PIN_CSRC];
	assign tick = ext_clock_mode ? pin_fall[PIN_XCLK] : int_tick;

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			div_q <= '0;
		else
			div_q <= int_tick ? '0 : div_q + DIV_W'(1);
	end

	// ==========================================================
	// Sequencer
	ecs_state_t           state_q, state_d;
	logic [CNT_W-1:0]     cnt_q, cnt_d, cnt_nx;
	logic [PTR_W-1:0]     idx_q, idx_d;
	logic [SEL_CNT_W-1:0] nsel_q, nsel_d;
	logic [SEL_CNT_W-1:0] stored_q, stored_d;
	logic                 eoc_n_q, eoc_n_d;
	logic                 standby_n_q, standby_n_d;
	logic                 first_conv;
	logic                 last_conv;
	logic                 start_ok;
	logic                 at_ptr;
	logic                 at_eoc;
	logic                 at_end;

	assign cnt_nx     = cnt_q + CNT_W'(1);
	assign first_conv = (idx_q == '0);
	assign last_conv  = (SEL_CNT_W'(idx_q) + SEL_CNT_W'(1) == nsel_q);
	// RQ21 start only when idle
	assign start_ok   = pin_rise[PIN_START] && (state_q == ECS_IDLE) && !standby_n_q;
	// RQ5 quiet until the 14th edge
	assign at_ptr     = tick && (state_q == ECS_CONV) && first_conv && (cnt_nx == CNT_W'(EDGE_PTR));
	assign at_eoc     = tick && (state_q == ECS_CONV) && (cnt_nx == CNT_W'(EDGE_EOC));
	assign at_end     = tick && (state_q != ECS_IDLE) && (cnt_nx == CNT_W'(EDGE_END));

	always_comb
	begin
		state_d  = state_q;
		cnt_d    = cnt_q;
		idx_d    = idx_q;
		nsel_d   = nsel_q;
		stored_d = stored_q;
		eoc_n_d  = eoc_n_q;
		case (state_q)
			ECS_IDLE:
			begin
				// RQ4 busy on start
				if (start_ok)
				begin
					state_d  = ECS_CONV;
					cnt_d    = '0;
					idx_d    = '0;
					nsel_d   = ecs_count_sel(channel_sel);
					stored_d = '0;
				end
			end
			ECS_CONV:
			begin
				// RQ7 end of conversion
				if (at_eoc)
				begin
					eoc_n_d  = 1'b0;
					stored_d = stored_q + SEL_CNT_W'(1);
					cnt_d    = cnt_nx;
					// RQ10 busy falls with the last result
					if (last_conv)
						state_d = ECS_TAIL;
				end
				// RQ9 next channel after 16 pulses
				else if (at_end)
				begin
					eoc_n_d = 1'b1;
					cnt_d   = '0;
					idx_d   = idx_q + PTR_W'(1);
				end
				else if (tick)
					cnt_d = cnt_nx;
			end
			ECS_TAIL:
			begin
				// RQ8 eoc returns high
				if (at_end)
				begin
					eoc_n_d = 1'b1;
					cnt_d   = '0;
					state_d = ECS_IDLE;
				end
				else if (tick)
					cnt_d = cnt_nx;
			end
			default:
				state_d = ECS_IDLE;
		endcase
	end

	// RQ12 enter standby
	// RQ13 leave standby
	// RQ22 standby deferred until idle
	assign standby_n_d = pin_q[PIN_STANDBY_N] ? 1'b0 : (standby_n_q || (state_q == ECS_IDLE));

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			state_q  <= ECS_IDLE;
			cnt_q    <= '0;
			idx_q    <= '0;
			nsel_q   <= '0;
			stored_q <= '0;
			eoc_n_q  <= 1'b1;
			standby_n_q   <= 1'b0;
		end
		else
		begin
			state_q  <= state_d;
			cnt_q    <= cnt_d;
			idx_q    <= idx_d;
			nsel_q   <= nsel_d;
			stored_q <= stored_d;
			eoc_n_q  <= eoc_n_d;
			standby_n_q   <= standby_n_d;
		end
	end

	// ==========================================================
	// Result registers and read pointer
	logic [DATA_W-1:0]    out_reg [NUM_REGS];
	logic [DATA_W-1:0]    sel_word;
	logic [PTR_W-1:0]     ptr_q, ptr_d;
	logic [SEL_CNT_W-1:0] ptr_nx;
	logic                 pend_q, pend_d;
	logic                 fwf_q, fwf_d;
	logic                 rd_rise;

	assign rd_rise  = pin_rise[PIN_RD] && !pin_q[PIN_CS];
	assign ptr_nx   = SEL_CNT_W'(ptr_q) + SEL_CNT_W'(1);
	assign sel_word = out_reg[ptr_q];

	always_comb
	begin
		ptr_d  = ptr_q;
		pend_d = pend_q;
		fwf_d  = fwf_q;
		// RQ6 pointer reset and first flag
		if (at_ptr)
		begin
			ptr_d  = '0;
			pend_d = 1'b0;
			fwf_d  = 1'b1;
		end
		// RQ19 held read advances on store
		else if (at_eoc && pend_q && (ptr_nx == SEL_CNT_W'(idx_q)))
		begin
			ptr_d  = ptr_nx[PTR_W-1:0];
			pend_d = 1'b0;
			fwf_d  = 1'b0;
		end
		else if (rd_rise && (stored_q != '0))
		begin
			if (state_q == ECS_CONV && ptr_nx >= stored_q)
				pend_d = 1'b1;
			else
			begin
				// RQ18 advance on read
				// RQ20 wrap after last result
				ptr_d = (ptr_nx >= stored_q) ? '0 : ptr_nx[PTR_W-1:0];
				fwf_d = (ptr_d == '0);
			end
		end
	end

	always_ff @(posedge clk)
	begin
		if (at_eoc)
			out_reg[idx_q] <= adc_result;
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
		begin
			ptr_q    <= '0;
			pend_q   <= 1'b0;
			fwf_q    <= 1'b0;
			data_out <= '0;
		end
		else
		begin
			ptr_q    <= ptr_d;
			pend_q   <= pend_d;
			fwf_q    <= fwf_d;
			data_out <= sel_word;
		end
	end

	// ==========================================================
	// Outputs
	// RQ11 read places addressed word
	// RQ14 drivers live in standby
	// RQ17 drive only on chip select and read
	assign data_oe        = !pin_q[PIN_CS] && !pin_q[PIN_RD];
	assign standby_active = standby_n_q;
	assign status.busy    = (state_q == ECS_CONV);
	assign status.eoc_n   = eoc_n_q;
	assign status.first_word_flag = fwf_q;

	// ==========================================================
	// Assertions
	a_busy_on_start: assert property (@(posedge clk) disable iff (rst) // RQ4
		start_ok |=> status.busy)
		else $error("busy did not rise after start");

	a_quiet_first_conv: assert property (@(posedge clk) disable iff (rst) // RQ5
		(status.busy && first_conv && cnt_q < CNT_W'(EDGE_PTR - 1)) |=> $stable(status))
		else $error("status changed before 14th edge");

	a_ptr_first_word: assert property (@(posedge clk) disable iff (rst) // RQ6
		at_ptr |=> (ptr_q == '0) && fwf_q)
		else $error("pointer or first flag wrong at 14th edge");

	a_eoc_store: assert property (@(posedge clk) disable iff (rst) // RQ7
		at_eoc |=> !eoc_n_q && (out_reg[$past(idx_q)] == $past(adc_result)))
		else $error("eoc low or result store missing");

	a_eoc_return: assert property (@(posedge clk) disable iff (rst) // RQ8
		(tick && !eoc_n_q) |=> eoc_n_q)
		else $error("eoc did not return high on next edge");

	a_last_busy_drop: assert property (@(posedge clk) disable iff (rst) // RQ10
		(at_eoc && last_conv) |=> !status.busy && !eoc_n_q)
		else $error("busy and eoc not low after last result");

	a_read_word: assert property (@(posedge clk) disable iff (rst) // RQ11
		data_oe |=> data_out == $past(sel_word))
		else $error("data out is not the addressed register");

	a_read_reg_one: assert property (@(posedge clk) disable iff (rst) // RQ11
		(data_oe && !eoc_n_q && first_conv) |=> data_out == out_reg[0])
		else $error("register 1 not on data bus while eoc low");

	a_ptr_wrap: assert property (@(posedge clk) disable iff (rst) // RQ20
		(rd_rise && !at_ptr && !status.busy && stored_q != '0 && ptr_nx >= stored_q)
		|=> ptr_q == '0 && fwf_q)
		else $error("pointer did not wrap to register 1");

	a_start_ignored: assert property (@(posedge clk) disable iff (rst) // RQ21
		(status.busy && !at_eoc && !at_end) |=> $stable(idx_q) && $stable(nsel_q))
		else $error("sequence disturbed while busy");

	a_standby_deferred: assert property (@(posedge clk) disable iff (rst) // RQ22
		(!pin_q[PIN_STANDBY_N] && !standby_n_q && state_q != ECS_IDLE) |=> !standby_n_q)
		else $error("standby entered during sequence");

endmodule : ecs_top

`default_nettype wire

// ### hdl/ecs_pkg.sv
// Constants, state encoding and carrier types for the conversion sequencer.
// Assumes a single 25 MHz system clock; every control pin except channel_sel is resynchronised inside the top.
package ecs_pkg;

	localparam int DATA_W     = 14;
	localparam int NUM_REGS   = 4;
	localparam int PTR_W      = 2;
	localparam int SEL_CNT_W  = 3;
	localparam int CNT_W      = 5;
	localparam int EDGE_PTR   = 14;
	localparam int EDGE_EOC   = 15;
	localparam int EDGE_END   = 16;

	// Internal conversion clock: one tick per bit period.
	localparam int CLK_MHZ    = 25;
	localparam int INT_CLK_NS = 150;
	localparam int INT_DIV    = (INT_CLK_NS * CLK_MHZ) / 1000;
	localparam int DIV_W      = 2;

	// Bit positions of the synchronised pin vector.
	localparam int PIN_HWSW   = 0;
	localparam int PIN_CSRC   = 1;
	localparam int PIN_START  = 2;
	localparam int PIN_XCLK   = 3;
	localparam int PIN_CS     = 4;
	localparam int PIN_RD     = 5;
	localparam int PIN_STANDBY_N   = 6;
	localparam int PIN_CNT    = 7;
	localparam logic [PIN_CNT-1:0] PIN_RST = 7'h7c;

	typedef enum logic [1:0]
	{
		ECS_IDLE = 2'h0,
		ECS_CONV = 2'h1,
		ECS_TAIL = 2'h3
	} ecs_state_t;

	typedef struct packed
	{
		logic busy;
		logic eoc_n;
		logic first_word_flag;
	} ecs_status_t;

	// Number of selected channels; an empty selection converts one channel.
	function automatic logic [SEL_CNT_W-1:0] ecs_count_sel(input logic [NUM_REGS-1:0] sel);
		logic [SEL_CNT_W-1:0] n;
		n = '0;
		for (int i = 0; i < NUM_REGS; i++)
		begin
			n = n + SEL_CNT_W'(sel[i]);
		end
		if (n == '0)
		begin
			n = SEL_CNT_W'(1);
		end
		return n;
	endfunction : ecs_count_sel

endpackage : ecs_pkg

// ### sim/ecs_host.sv
// Host model: drives the conversion start pin and the external conversion clock.
// Assumes the bench calls its tasks from one process; clk is the 25 MHz system clock.
`timescale 1ns/1ns
`default_nettype none

module ecs_host (
	input  wire logic clk,
	output logic      conv_start_n,
	output logic      ext_conv_clock
);
	// ==========================================================
	// Pin drivers
	initial
	begin
		conv_start_n = 1'b1;
		ext_conv_clock = 1'b1;
	end

	task automatic start();
		@(posedge clk);
		conv_start_n <= 1'b0;
		repeat (5) @(posedge clk);
		conv_start_n <= 1'b1;
		repeat (8) @(posedge clk);
	endtask : start

	task automatic tick();
		@(posedge clk);
		ext_conv_clock <= 1'b0;
		repeat (3) @(posedge clk);
		ext_conv_clock <= 1'b1;
		repeat (3) @(posedge clk);
	endtask : tick
endmodule : ecs_host

`default_nettype wire

// ### sim/tb_top.sv
// Self-checking bench for the conversion sequencer in external and internal clock modes.
// Assumes the host model in ecs_host.sv and pin sync of about four clk.
`timescale 1ns/1ns
`default_nettype none

module tb_top;
	import ecs_pkg::*;
	logic                clk                 = 1'b0;
	logic                rst                 = 1'b1;
	logic                hw_sw_select        = 1'b0;
	logic                clock_source_select = 1'b1;
	logic                cs_n                = 1'b1;
	logic                rd_n                = 1'b1;
	logic                standby_n           = 1'b1;
	logic [NUM_REGS-1:0] channel_sel         = 4'h3;
	logic [DATA_W-1:0]   adc_result          = 14'h0000;
	logic                conv_start_n;
	logic                ext_conv_clock;
	ecs_status_t         status;
	logic [DATA_W-1:0]   data_out;
	logic                data_oe;
	logic                standby_active;
	logic                ext_clock_mode;
	logic                fwf_e;
	logic [DATA_W-1:0]   res [NUM_REGS];
	int                  err_total = 0;
	int                  num_checks = 0;

	always #20 clk = ~clk;

	ecs_top dut_u (.clk(clk), .rst(rst), .hw_sw_select(hw_sw_select),
		.clock_source_select(clock_source_select), .conv_start_n(conv_start_n),
		.ext_conv_clock(ext_conv_clock), .cs_n(cs_n), .rd_n(rd_n), .standby_n(standby_n),
		.channel_sel(channel_sel), .adc_result(adc_result), .status(status),
		.data_out(data_out), .data_oe(data_oe), .standby_active(standby_active),
		.ext_clock_mode(ext_clock_mode));

	ecs_host host_u (.clk(clk), .conv_start_n(conv_start_n), .ext_conv_clock(ext_conv_clock));

	// ==========================================================
	// Helpers
	task automatic end_of_test();
		if (err_total == 0 && num_checks > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		#1;
		num_checks++;
		if (got !== exp)
		begin
			err_total++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask : cyc

	task automatic rd_word(input logic [DATA_W-1:0] exp, input logic fa);
		@(posedge clk);
		cs_n <= 1'b0;
		rd_n <= 1'b0;
		cyc(6);
		chk(data_oe, 1'b1);
		chk(data_out, exp);
		@(posedge clk);
		rd_n <= 1'b1;
		cyc(6);
		chk(data_oe, 1'b0);
		chk(status.first_word_flag, fa);
		@(posedge clk);
		cs_n <= 1'b1;
	endtask : rd_word

	// Runs n conversions tick by tick; mid adds a read, a restart and standby.
	task automatic run_seq(input int n, input bit mid);
		int k;
		int e;
		for (int i = 0; i < NUM_REGS; i++)
			res[i] = 14'h1a50 + DATA_W'(i) + (mid ? 14'h0000 : 14'h0100);
		host_u.start();
		chk(status.busy, 1'b1);
		for (int t = 1; t <= 16 * n; t++)
		begin
			k = (t - 1) / 16;
			e = (t - 1) % 16 + 1;
			@(posedge clk);
			adc_result <= res[k];
			if (mid && t == 21)
				standby_n <= 1'b0;
			if (mid && t == 5)
				host_u.start();
			if (k == 0 && e == 14)
				fwf_e = 1'b1;
			if (mid && k == 1 && e == 15)
				fwf_e = 1'b0;
			host_u.tick();
			chk(status.eoc_n, e != 15);
			chk(status.busy, !(k == n - 1 && e >= 15));
			chk(status.first_word_flag, fwf_e);
			if (mid && t > 21 && t < 16 * n)
				chk(standby_active, 1'b0);
			if (mid && t == 15)
				rd_word(res[0], 1'b1);
		end
	endtask : run_seq

	// ==========================================================
	// Main sequence
	initial
	begin
		fwf_e = 1'b0;
		cyc(5);
		rst <= 1'b0;
		cyc(6);
		chk(status, 16'h0002);
		chk(ext_clock_mode, 1'b0);
		@(posedge clk);
		hw_sw_select <= 1'b1;
		rd_n <= 1'b0;
		cyc(6);
		chk(ext_clock_mode, 1'b1);
		chk(data_oe, 1'b0);
		@(posedge clk);
		rd_n <= 1'b1;
		cyc(6);
		run_seq(2, 1'b1);
		chk(standby_active, 1'b1);
		rd_word(res[1], 1'b1);
		rd_word(res[0], 1'b0);
		@(posedge clk);
		standby_n <= 1'b1;
		cyc(6);
		chk(standby_active, 1'b0);
		cyc(130);
		channel_sel <= 4'h0;
		run_seq(1, 1'b0);
		rd_word(res[0], 1'b1);
		@(posedge clk);
		hw_sw_select <= 1'b0;
		cyc(6);
		chk(ext_clock_mode, 1'b0);
		host_u.start();
		chk(status.busy, 1'b1);
		for (int w = 0; w < 100 && status.busy; w++)
			@(posedge clk);
		chk(status.busy, 1'b0);
		if (status.busy)
			end_of_test();
		cyc(10);
		chk(status, 16'h0003);
		rd_word(res[0], 1'b1);
		end_of_test();
	end

	initial
	begin
		#200000;
		err_total++;
		end_of_test();
	end
endmodule : tb_top

`default_nettype wire
